// file: verilog/dac_serial_write_control.sv
// Purpose: Frame decoder and control registers of a 16-bit serial DAC.
// Assumes: Shift clock sampled by core_clk; its period spans >= 3 cycles.
// Notes:   Analog core is outside; this block drives its control levels.

`timescale 1ns/1ps
`default_nettype none

module dac_serial_write_control #(
    parameter bit LOW_SUPPLY = 1'b0
) (
    // Clock and reset.
    input  wire logic                                core_clk,
    input  wire logic                                resetn,
    // Serial frame pins.
    input  wire logic                                sync_n,
    input  wire logic                                sclk,
    input  wire logic                                din,
    // DAC core controls.
    output logic [dac_serial_pkg::CODE_BITS-1:0]     dac_code,
    output logic [dac_serial_pkg::CODE_BITS-1:0]     restart_code,
    output dac_serial_pkg::mode_t                    op_mode,
    output logic                                     amp_connect,
    output logic                                     linear_on,
    output logic                                     term_100k,
    output logic                                     term_1k,
    output logic                                     output_settled,
    // Frame status pulses.
    output logic                                     word_done,
    output logic                                     word_abort
);

    import dac_serial_pkg::*;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------

    localparam logic [WAKE_BITS-1:0] WAKE_CYC = LOW_SUPPLY ?
        WAKE_BITS'(WAKE_3V_CYC) : WAKE_BITS'(WAKE_5V_CYC);
    localparam logic [WAKE_BITS-1:0] WAKE_ZERO = '0;
    localparam logic [WAKE_BITS-1:0] WAKE_ONE  = WAKE_BITS'(1);
    localparam logic [CNT_BITS-1:0]  CNT_ONE   = CNT_BITS'(1);

    // Pins reset to their idle levels: select high, clock and data low.
    localparam logic [PIN_NUM-1:0]   PIN_IDLE  = 3'h2;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    logic [PIN_NUM-1:0] pin_meta;
    logic [PIN_NUM-1:0] pin_sync;
    logic               sclk_prev;
    logic               sync_prev;

    // Two flip-flops per pin; only the second stage feeds logic.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= {din, sync_n, sclk};
            pin_sync <= pin_meta;
        end
    end

    // Previous sampled levels for edge detection.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev <= 1'b0;
            sync_prev <= 1'b1;
        end else begin
            sclk_prev <= pin_sync[PIN_SCLK];
            sync_prev <= pin_sync[PIN_SYNC];
        end
    end

    // ------------------------------------------------------------------
    // Edge decode
    // ------------------------------------------------------------------

    // Data comes from the same stage as the clock, so each bit is read
    // exactly as the pin stood when the falling edge was seen.
    wire sync_lvl  = pin_sync[PIN_SYNC];
    wire din_lvl   = pin_sync[PIN_DIN];
    wire sclk_fall = sclk_prev & ~pin_sync[PIN_SCLK];
    wire sync_fall = sync_prev & ~sync_lvl;

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------

    frame_state_t               state;
    frame_state_t               next_state;
    logic [WORD_BITS-1:0]       shift;
    logic [CNT_BITS-1:0]        bit_cnt;
    logic                       swr_armed;

    // Shifting happens only inside a frame with select low.
    wire in_frame = (state == ST_SHIFT) & ~sync_lvl;
    wire take_bit = in_frame & sclk_fall; // RL2
    wire last_bit = take_bit & (bit_cnt == LAST_CNT); // RL3
    // Early rise of select ends the frame before the last edge.
    wire early_rise = (state == ST_SHIFT) & sync_lvl; // RL13
    // Complete word as seen on the final edge, first bit at the top.
    wire [WORD_BITS-1:0] full_word = {shift[WORD_BITS-2:0], din_lvl}; // RL19

    // A frame whose first byte is all ones is a software reset if it ends early or all 24 bits are ones.
    wire swr_seen = (state == ST_SHIFT) & (bit_cnt == SWR_CNT)
                  & (shift[SWR_BITS-1:0] == SWR_TOP); // RL15

    // A reset word counts as begun from the cycle its first byte is seen.
    wire swr_live = swr_armed | swr_seen; // RL16

    // Decoded actions.
    wire do_swr   = (last_bit & (full_word == SWR_WORD))
                  | (early_rise & swr_live); // RL15 RL16
    wire do_write = last_bit & (full_word != SWR_WORD); // RL3
    wire do_abort = early_rise & ~swr_live; // RL13

    // Next-state selection.
    // The done state swallows stray clock edges after the last bit until
    // select has been high; only a fresh falling select opens a frame.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (sync_fall) begin
                    next_state = ST_SHIFT; // RL1
                end
            end
            ST_SHIFT: begin
                if (early_rise) begin
                    next_state = ST_IDLE;
                end else if (last_bit) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (sync_lvl) begin
                    next_state = ST_IDLE; // RL20
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Shift register and bit counter; cleared at frame start and abort.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            shift   <= '0;
            bit_cnt <= '0;
        end else if (sync_fall || early_rise) begin
            shift   <= '0; // RL1 RL13
            bit_cnt <= '0;
        end else if (take_bit) begin
            shift   <= full_word; // RL2
            bit_cnt <= bit_cnt + CNT_ONE;
        end
    end

    // Software reset marker, held from its first byte to frame end.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            swr_armed <= 1'b0;
        end else if (state != ST_SHIFT) begin
            swr_armed <= 1'b0;
        end else if (swr_seen) begin
            swr_armed <= 1'b1; // RL16
        end
    end

    // ------------------------------------------------------------------
    // Command execution
    // ------------------------------------------------------------------

    wire [CODE_BITS-1:0] word_code = full_word[CODE_BITS-1:0]; // RL12
    wire                 word_rst  = full_word[RESTART_BIT];
    wire [1:0]           word_mode =
        {full_word[MODE_HI_BIT], full_word[MODE_LO_BIT]}; // RL8

    mode_t next_mode;

    // Mode after this cycle.
    always_comb begin
        next_mode = op_mode;
        if (do_swr) begin
            next_mode = MODE_NORMAL;
        end else if (do_write) begin
            next_mode = mode_t'(word_mode); // RL9
        end
    end

    // Output code register; zero from power-on until a valid write.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dac_code <= CODE_RESET; // RL14
        end else if (do_swr) begin
            dac_code <= restart_code; // RL15
        end else if (do_write) begin
            dac_code <= word_code; // RL12
        end
    end

    // Restart code register, kept until power is removed.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            restart_code <= CODE_RESET;
        end else if (do_write && word_rst) begin
            restart_code <= word_code; // RL7
        end
    end

    // Operating mode register; code register is untouched by mode.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            op_mode <= MODE_NORMAL;
        end else begin
            op_mode <= next_mode; // RL10
        end
    end

    // ------------------------------------------------------------------
    // Output stage controls
    // ------------------------------------------------------------------

    wire next_pd = (next_mode != MODE_NORMAL);

    // Termination and bias follow the next mode so all change together.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            amp_connect <= 1'b1;
            linear_on   <= 1'b1;
            term_100k   <= 1'b0;
            term_1k     <= 1'b0;
        end else begin
            amp_connect <= ~next_pd; // RL10
            linear_on   <= ~next_pd;
            term_100k   <= (next_mode == MODE_R100K); // RL9
            term_1k     <= (next_mode == MODE_R1K);
        end
    end

    // ------------------------------------------------------------------
    // Wake-up timer
    // ------------------------------------------------------------------

    // The timer restarts each time power-down is left, so a short stay in
    // normal mode never reports a settled output too early.
    logic [WAKE_BITS-1:0] wake_cnt;

    wire waking = (op_mode != MODE_NORMAL) & ~next_pd;

    // Counts the settle time after leaving power-down.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wake_cnt <= WAKE_ZERO;
        end else if (next_pd) begin
            wake_cnt <= WAKE_ZERO;
        end else if (waking) begin
            wake_cnt <= WAKE_CYC; // RL11
        end else if (wake_cnt != WAKE_ZERO) begin
            wake_cnt <= wake_cnt - WAKE_ONE;
        end
    end

    // Settled flag: normal mode and timer expired.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            output_settled <= 1'b1;
        end else begin
            output_settled <= ~next_pd & ~waking
                & ((wake_cnt == WAKE_ZERO) | (wake_cnt == WAKE_ONE)); // RL11
        end
    end

    // ------------------------------------------------------------------
    // Status pulses
    // ------------------------------------------------------------------

    // One-cycle pulses for executed and discarded frames.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            word_done  <= 1'b0;
            word_abort <= 1'b0;
        end else begin
            word_done  <= do_write | do_swr;
            word_abort <= do_abort; // RL13
        end
    end

endmodule

`default_nettype wire

// file: verilog/dac_serial_pkg.sv
// Purpose: Constants and types for the serial DAC write control block.
// Assumes: core_clk at 50 MHz samples the three frame pins.
// Notes:   Summary of operation follows.
//
// Summary of operation
// (RL1) A falling frame select starts a write and enables the shift register.
// (RL2) While frame select is low, each falling shift clock shifts in one bit.
// (RL3) The 24th falling edge completes the word and executes it at once.
// (RL4) The host keeps the shift clock at or below 30 MHz.
// (RL5) The host holds frame select high at least 33 ns between words.
// (RL6) The host may idle frame select low but pulses it high before a word.
// (RL7) Bit 22 set loads the data into the restart code register.
// (RL8) Bits 21 and 20 carry the operating mode.
// (RL9) Mode 00 normal, 01 open output, 10 100k to ground, 11 1k to ground.
// (RL10) Power-down detaches the amplifier, adds termination, keeps the code.
// (RL11) Leaving power-down, output settles after 2.5 us (5 V) or 5 us (3 V).
// (RL12) The 16 low data bits go to the output code register on edge 24.
// (RL13) Frame select rising before edge 24 clears the word, changes nothing.
// (RL14) After power-on the output code is zero until a valid write.
// (RL15) A word of all ones performs a software reset.
// (RL16) Once a software reset word has begun, an early rise does not abort it.
// (RL17) A byte-wide host keeps frame select low across all bytes of a word.
// (RL18) An SPI host uses polarity 0, phase 1, data valid at falling edges.
// (RL19) The host sends each word most significant bit first.
// (RL20) After executing, edges are ignored until frame select rises and falls.

package dac_serial_pkg;

    // Word layout.
    localparam int WORD_BITS   = 24;
    localparam int CODE_BITS   = 16;
    localparam int CNT_BITS    = 5;
    localparam int RESTART_BIT = 22;
    localparam int MODE_HI_BIT = 21;
    localparam int MODE_LO_BIT = 20;
    localparam int SWR_BITS    = 8;

    localparam logic [CNT_BITS-1:0] LAST_CNT =
        CNT_BITS'(WORD_BITS - 1);
    localparam logic [CNT_BITS-1:0] SWR_CNT = CNT_BITS'(SWR_BITS);
    localparam logic [SWR_BITS-1:0] SWR_TOP = 8'hFF;
    localparam logic [WORD_BITS-1:0] SWR_WORD = 24'hFFFFFF;

    // Reset values.
    localparam logic [CODE_BITS-1:0] CODE_RESET = 16'h0000;

    // Pin indices inside the synchroniser vector.
    localparam int PIN_SCLK = 0;
    localparam int PIN_SYNC = 1;
    localparam int PIN_DIN  = 2;
    localparam int PIN_NUM  = 3;

    // Timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_5V_NS    = 2500;
    localparam int WAKE_3V_NS    = 5000;
    localparam int WAKE_BITS     = 9;
    localparam int WAKE_5V_CYC =
        (WAKE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_3V_CYC =
        (WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Operating modes.
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_OPEN   = 2'b01,
        MODE_R100K  = 2'b10,
        MODE_R1K    = 2'b11
    } mode_t;

    // Frame states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b10
    } frame_state_t;

endpackage

// file: testbench/dac_serial_write_control_chk.sv
// Purpose: Port-level checks of the serial DAC write control block.
// Assumes: One clock domain, core_clk, with resetn active low.
// Notes:   Bound to the block from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_control_chk
    import dac_serial_pkg::*;
#(
    parameter bit LOW_SUPPLY = 1'b0
) (
    // Clock and reset.
    input wire logic                     core_clk,
    input wire logic                     resetn,
    // Control levels.
    input wire logic [CODE_BITS-1:0]     dac_code,
    input wire logic [CODE_BITS-1:0]     restart_code,
    input wire dac_serial_pkg::mode_t    op_mode,
    input wire logic                     amp_connect,
    input wire logic                     linear_on,
    input wire logic                     term_100k,
    input wire logic                     term_1k,
    input wire logic                     output_settled,
    // Status pulses.
    input wire logic                     word_done,
    input wire logic                     word_abort
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int WAKE    = LOW_SUPPLY ? WAKE_3V_CYC : WAKE_5V_CYC;
    localparam int WAKE_LO = WAKE - 4;
    localparam int WAKE_HI = WAKE + 4;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // The edge at which power-down is left for normal mode.
    sequence leave_pd;
        op_mode == MODE_NORMAL && $past(op_mode) != MODE_NORMAL;
    endsequence

    // The output stays unsettled through the start of the wake time.
    sequence wake_wait;
        !output_settled [*8];
    endsequence

    a_done_excl: assert property (!(word_done && word_abort))
        else $error("done and abort in one cycle");
    a_done_pulse: assert property (word_done |=> !word_done)
        else $error("done longer than one cycle");
    a_code_hold: assert property ($changed(dac_code) |-> word_done)
        else $error("code changed without a word");
    a_mode_hold: assert property ($changed(op_mode) |-> word_done)
        else $error("mode changed without a word");
    a_restart_load: assert property ($changed(restart_code) |->
        word_done && restart_code == dac_code)
        else $error("restart code loaded badly");
    a_term_decode: assert property ((term_1k == (op_mode == MODE_R1K)) &&
        (term_100k == (op_mode == MODE_R100K)))
        else $error("termination does not follow mode");
    a_amp_decode: assert property ((amp_connect == (op_mode == MODE_NORMAL))
        && (linear_on == (op_mode == MODE_NORMAL)))
        else $error("amplifier does not follow mode");
    a_pd_unsettled: assert property (op_mode != MODE_NORMAL &&
        $past(op_mode) != MODE_NORMAL |-> !output_settled)
        else $error("settled while powered down");
    a_wake_hold: assert property (leave_pd |-> wake_wait)
        else $error("settled too early after wake");
    a_wake_end: assert property (leave_pd |->
        ##[WAKE_LO:WAKE_HI] output_settled)
        else $error("not settled after wake time");
endmodule
`default_nettype wire

// file: testbench/dac_host_model.sv
// Purpose: Host side of the three-wire link, polarity 0 phase 1.
// Assumes: 160 ns shift clock made from 4+4 core_clk cycles.
// Notes:   Data line is driven inverted once a frame ends.
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
    // Clock.
    input  wire logic core_clk,
    // Frame pins.
    output logic      sync_n,
    output logic      sclk,
    output logic      din
);
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    // Idle pins: frame deselected, shift clock low.
    initial begin
        sync_n = 1'b1;
        sclk   = 1'b0;
        din    = 1'b0;
    end

    // Waits k core clock edges.
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    // Sends the top n bits of w, then extra edges with the frame held.
    task automatic send(input logic [23:0] w, input int n,
                        input int extra, input bit idle);
        int i;
        @(posedge core_clk);
        if (sync_n === 1'b0) begin
            sync_n <= 1'b1;
            tick(4);
        end
        sync_n <= 1'b0;
        tick(4);
        for (i = 0; i < n + extra; i++) begin
            sclk <= 1'b1;
            din  <= w[23 - (i % 24)];
            tick(4);
            sclk <= 1'b0;
            tick(4);
            if (i % 8 == 7) tick(8);
        end
        din    <= ~din;
        sync_n <= 1'b1;
        tick(4);
        if (idle) sync_n <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: testbench/dac_serial_write_control_tb_top.sv
// Purpose: Self-checking bench of the serial DAC write control block.
// Assumes: Host model drives the pins; 50 MHz core clock.
// Notes:   Counts done and abort pulses to check framing.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_control_tb_top;
    import dac_serial_pkg::*;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    localparam bit LOW_SUPPLY = 1'b0;
    logic              core_clk, resetn, sync_n, sclk, din;
    logic [15:0]       dac_code, restart_code;
    mode_t             op_mode;
    logic              amp_connect, linear_on, term_100k, term_1k;
    logic              output_settled, word_done, word_abort;
    int                miscompares, n_tests, n_done, n_abort, i;
    logic [1:0]        modes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int                abl [2] = '{12, 23};

    dac_serial_write_control #(.LOW_SUPPLY(LOW_SUPPLY))
        i_dac_serial_write_control (.core_clk, .resetn, .sync_n, .sclk,
        .din, .dac_code, .restart_code, .op_mode, .amp_connect,
        .linear_on, .term_100k, .term_1k, .output_settled, .word_done,
        .word_abort);
    dac_host_model i_dac_host_model (.core_clk, .sync_n, .sclk, .din);

    // Clock and pulse counters.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (word_done === 1'b1) n_done++;
        if (word_abort === 1'b1) n_abort++;
    end

    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input string nm, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask

    // One frame from the host, then time for the pulses to land.
    task automatic xfer(input logic [23:0] w, input int n,
                        input int extra = 0, input bit idle = 1'b0);
        i_dac_host_model.send(w, n, extra, idle);
        repeat (6) @(posedge core_clk);
    endtask

    // Checks the code and every level that follows the mode.
    task automatic out_chk(input logic [15:0] code, input logic [1:0] md);
        chk("dac_code", dac_code, code);
        chk("op_mode", 16'(op_mode), 16'(md));
        chk("stage", 16'({amp_connect, linear_on, term_100k, term_1k}),
            16'({md == 2'h0, md == 2'h0, md == 2'h2, md == 2'h3}));
    endtask

    // Hang guard.
    initial begin
        #1ms;
        miscompares++;
        finish_test();
    end

    // Main sequence.
    initial begin
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        out_chk(CODE_RESET, 2'h0);
        chk("restart", restart_code, 16'h0000);
        chk("settled", 16'(output_settled), 16'h0001);
        xfer(24'h001234, 24, 3);
        out_chk(16'h1234, 2'h0);
        chk("done", 16'(n_done), 16'h0001);
        foreach (modes[k]) begin
            xfer({2'h0, modes[k], 4'hF, 16'hA000 + 16'(k)}, 24);
            out_chk(16'hA000 + 16'(k), modes[k]);
        end
        chk("settled", 16'(output_settled), 16'h0000);
        for (i = 0; i < 200 && output_settled !== 1'b1; i++)
            @(posedge core_clk);
        if (i == 200) begin
            miscompares++;
            finish_test();
        end
        chk("wake", 16'(i > WAKE_5V_CYC - 30 && i < WAKE_5V_CYC),
            16'h0001);
        foreach (abl[k]) begin
            xfer(24'h205555, abl[k]);
            out_chk(16'hA003, 2'h0);
        end
        chk("abort", 16'(n_abort), 16'h0002);
        chk("done", 16'(n_done), 16'h0005);
        xfer(24'h405A5A, 24, 0, 1'b1);
        chk("restart", restart_code, 16'h5A5A);
        xfer(24'h301111, 24);
        out_chk(16'h1111, 2'h3);
        xfer(24'hFFFFFF, 24);
        out_chk(16'h5A5A, 2'h0);
        chk("restart", restart_code, 16'h5A5A);
        xfer(24'h102222, 24);
        out_chk(16'h2222, 2'h1);
        xfer(24'hFFFFFF, 12);
        out_chk(16'h5A5A, 2'h0);
        finish_test();
    end
endmodule

bind dac_serial_write_control dac_serial_write_control_chk #(
    .LOW_SUPPLY(LOW_SUPPLY)
) i_chk (.core_clk, .resetn, .dac_code, .restart_code, .op_mode,
    .amp_connect, .linear_on, .term_100k, .term_1k, .output_settled,
    .word_done, .word_abort);
`default_nettype wire
